/* core/cewb_pkg.sv */
// Purpose: constants and types for exposure, gain and white-balance control
// Assumes: 250 MHz core clock; register addresses are the setting-command numbers
// Notes on behaviour
// - manual gain code applies manual value in tenths of dB, 0 to 42 dB
// - continuous exposure counts sensor lines; fixed trigger exposure counts microseconds
// - actual shutter time is programmed value plus a fixed 14 us extension
// - continuous manual exposure longer than the frame is limited to frame maximum
// - exposure readback shows clipped value; original setting returns when size restores
// - fixed trigger exposure setting is at least 6 us, 20 us effective
// - trigger modes never clip exposure; effective is setting plus extension
// - shutter mode selects continuous, fixed trigger or pulse width; resets to continuous
// - continuous mode free-runs without triggers; next exposure overlaps current readout
// - separate continuous and trigger exposure settings; continuous one used only there
// - continuous exposure period is latched on line boundaries
// - fixed trigger edge starts exposure of programmed length; trigger sampled on clock
// - exposure starts within 50 ns of a detected trigger edge
// - pulse width exposure ends within 14 us after the trailing trigger edge
// - trigger edge during frame readout in trigger modes stops video output
// - white balance select: 0 off, 1 manual gains, 2 one-shot gains
// - manual red and blue gains accepted from 0 to 800 percent
// - one-shot start measures current image, only while one-shot selected
// - one-shot measurement runs only while video is output
// - preset shutter mode applies an internally stored exposure value
// - preset gain codes 0 to 7 give 0 to 42 dB in 6 dB steps
package cewb_pkg;
  localparam logic [11:0] ADDR_SYNC_RESET  = 12'h01d;
  localparam logic [11:0] ADDR_BIT_DEPTH   = 12'h028;
  localparam logic [11:0] ADDR_OP_MODE     = 12'h029;
  localparam logic [11:0] ADDR_LINK_CLK    = 12'h031;
  localparam logic [11:0] ADDR_SHUT_MODE   = 12'h033;
  localparam logic [11:0] ADDR_TRIG_POL    = 12'h034;
  localparam logic [11:0] ADDR_TRIG_SRC    = 12'h035;
  localparam logic [11:0] ADDR_GAIN_SEL    = 12'h064;
  localparam logic [11:0] ADDR_GAIN_MAN    = 12'h065;
  localparam logic [11:0] ADDR_GAIN_NOW    = 12'h068;
  localparam logic [11:0] ADDR_EXP_CONT    = 12'h06e;
  localparam logic [11:0] ADDR_EXP_TRIG    = 12'h06f;
  localparam logic [11:0] ADDR_PRESET_SHUT = 12'h070;
  localparam logic [11:0] ADDR_EXP_NOW     = 12'h072;
  localparam logic [11:0] ADDR_WB_SEL      = 12'h08c;
  localparam logic [11:0] ADDR_WB_START    = 12'h08d;
  localparam logic [11:0] ADDR_WB_RED      = 12'h08e;
  localparam logic [11:0] ADDR_WB_BLUE     = 12'h08f;
  localparam logic [11:0] ADDR_H_MIRROR    = 12'h386;
  localparam logic [11:0] ADDR_V_MIRROR    = 12'h387;

  localparam logic [15:0] SHUT_CONT        = 16'h0000;
  localparam logic [15:0] SHUT_FIXED       = 16'h0001;
  localparam logic [15:0] SHUT_PULSE       = 16'h0002;
  localparam logic [15:0] GAIN_MANUAL      = 16'h000f;
  localparam logic [15:0] GAIN_TOP_CODE    = 16'h0007;
  localparam logic [15:0] GAIN_STEP_X10    = 16'h003c;
  localparam logic [15:0] GAIN_MAX_X10     = 16'h01a4;
  localparam logic [15:0] PRESET_MANUAL    = 16'h0001;
  localparam logic [15:0] WB_OFF           = 16'h0000;
  localparam logic [15:0] WB_MANUAL        = 16'h0001;
  localparam logic [15:0] WB_ONESHOT       = 16'h0002;
  localparam logic [15:0] WB_UNITY_PCT     = 16'h0064;
  localparam logic [15:0] WB_MAX_PCT       = 16'h0320;
  localparam logic [15:0] RST_ZERO         = 16'h0000;

  localparam int CLK_MHZ        = 250;
  localparam int EXT_US         = 14;
  localparam int EXT_CYC        = EXT_US * CLK_MHZ;
  localparam int MIN_TRIG_US    = 6;
  localparam int START_MAX_NS   = 50;
  localparam int START_MAX_CYC  = START_MAX_NS * CLK_MHZ / 1000;
  localparam int VBLANK_CONT    = 50;
  localparam int VBLANK_TRIG    = 62;
  localparam int DIV_BITS       = 10;

  typedef struct packed {
    logic [15:0] bit_depth;
    logic [15:0] op_mode;
    logic [15:0] link_clk;
    logic [15:0] h_mirror;
    logic [15:0] v_mirror;
  } cewb_cfg_t;

  typedef struct packed {
    logic [15:0] red_pct;
    logic [15:0] blue_pct;
  } cewb_wb_t;
endpackage

/* core/cewb_ctrl.sv */
// Purpose: exposure timing, shutter modes, gain and white-balance control
// Assumes: setting commands and pixel stream on core clock; trigger pins asynchronous
// Notes: one-shot gains divide green sum by red or blue sum over one frame
`timescale 1ns/1ps
`default_nettype none
module cewb_ctrl #(
  parameter int LINE_CYC          = 724,
  parameter int PRESET_CONT_LINES = 500,
  parameter int PRESET_TRIG_US    = 1000
) (
  input  wire logic                core_clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                ce_in,
  input  wire logic                cmd_valid_in,
  input  wire logic                cmd_write_in,
  input  wire logic [11:0]         cmd_addr_in,
  input  wire logic [15:0]         cmd_data_in,
  output logic                     rsp_valid_out,
  output logic [15:0]              rsp_data_out,
  input  wire logic                trig_pin_in,
  input  wire logic                trig_link_in,
  input  wire logic [15:0]         active_lines_in,
  input  wire logic                pix_valid_in,
  input  wire logic [11:0]         pix_red_in,
  input  wire logic [11:0]         pix_green_in,
  input  wire logic [11:0]         pix_blue_in,
  output logic                     exposure_out,
  output logic                     frame_valid_out,
  output logic                     video_halted_out,
  output logic                     wb_busy_out,
  output logic [15:0]              gain_x10_out,
  output cewb_pkg::cewb_wb_t       wb_out,
  output cewb_pkg::cewb_cfg_t      cfg_out
);
  import cewb_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_EXPOSE, ST_EXTEND, ST_READOUT} cewb_st_t;
  typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_SUM, OS_DIV} cewb_os_t;

  logic [15:0] shut_mode_reg, trig_pol_reg, trig_src_reg, gain_sel_reg, gain_man_reg;
  logic [15:0] exp_cont_reg, exp_trig_reg, preset_shut_reg, wb_sel_reg;
  logic [15:0] wb_red_reg, wb_blue_reg, gain_reg;
  cewb_cfg_t   cfg_reg;
  cewb_wb_t    wb_reg;
  cewb_st_t    state_reg;
  cewb_os_t    os_reg;
  logic        wr_en, rd_en, sync_rst_wr, wb_start_wr, is_cont, is_pulse;
  logic        rsp_valid_reg, halted_reg;
  logic [15:0] rsp_data_reg, rd_data;

  //////////////////////////////////////////////////////////////////////////
  // setting commands

  assign wr_en       = cmd_valid_in & cmd_write_in & ce_in;
  assign rd_en       = cmd_valid_in & ~cmd_write_in & ce_in;
  assign sync_rst_wr = wr_en && (cmd_addr_in == ADDR_SYNC_RESET);
  assign wb_start_wr = wr_en && (cmd_addr_in == ADDR_WB_START);
  assign is_cont     = (shut_mode_reg == SHUT_CONT);
  assign is_pulse    = (shut_mode_reg == SHUT_PULSE);

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      shut_mode_reg   <= SHUT_CONT;
      trig_pol_reg    <= RST_ZERO;
      trig_src_reg    <= RST_ZERO;
      gain_sel_reg    <= RST_ZERO;
      gain_man_reg    <= RST_ZERO;
      exp_cont_reg    <= RST_ZERO;
      exp_trig_reg    <= RST_ZERO;
      preset_shut_reg <= PRESET_MANUAL;
      wb_sel_reg      <= WB_OFF;
      wb_red_reg      <= WB_UNITY_PCT;
      wb_blue_reg     <= WB_UNITY_PCT;
      cfg_reg         <= '0;
    end
    else if (wr_en)
    begin
      case (cmd_addr_in)
        ADDR_SHUT_MODE:   shut_mode_reg   <= cmd_data_in;
        ADDR_TRIG_POL:    trig_pol_reg    <= cmd_data_in;
        ADDR_TRIG_SRC:    trig_src_reg    <= cmd_data_in;
        ADDR_GAIN_SEL:    gain_sel_reg    <= cmd_data_in;
        ADDR_GAIN_MAN:    gain_man_reg    <= cmd_data_in;
        ADDR_EXP_CONT:    exp_cont_reg    <= cmd_data_in;
        ADDR_EXP_TRIG:    exp_trig_reg    <= cmd_data_in;
        ADDR_PRESET_SHUT: preset_shut_reg <= cmd_data_in;
        ADDR_WB_SEL:      wb_sel_reg      <= cmd_data_in;
        ADDR_WB_RED:      wb_red_reg      <= cmd_data_in;
        ADDR_WB_BLUE:     wb_blue_reg     <= cmd_data_in;
        ADDR_BIT_DEPTH:   cfg_reg.bit_depth <= cmd_data_in;
        ADDR_OP_MODE:     cfg_reg.op_mode   <= cmd_data_in;
        ADDR_LINK_CLK:    cfg_reg.link_clk  <= cmd_data_in;
        ADDR_H_MIRROR:    cfg_reg.h_mirror  <= cmd_data_in;
        ADDR_V_MIRROR:    cfg_reg.v_mirror  <= cmd_data_in;
        default:          ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // trigger input

  logic [1:0] pin_sync_reg, link_sync_reg;
  logic       trig_lvl, trig_q_reg, trig_rise, trig_fall;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pin_sync_reg  <= 2'h0;
      link_sync_reg <= 2'h0;
      trig_q_reg    <= 1'b0;
    end
    else if (ce_in)
    begin
      pin_sync_reg  <= {pin_sync_reg[0], trig_pin_in};
      link_sync_reg <= {link_sync_reg[0], trig_link_in};
      trig_q_reg    <= trig_lvl;
    end
  end

  // polarity applied after the second stage so edges are never taken from a metastable flop
  assign trig_lvl  = (trig_src_reg[0] ? link_sync_reg[1] : pin_sync_reg[1]) ^ trig_pol_reg[0];
  assign trig_rise = trig_lvl & ~trig_q_reg;
  assign trig_fall = ~trig_lvl & trig_q_reg;

  //////////////////////////////////////////////////////////////////////////
  // exposure values

  logic [15:0] frame_total, cont_src, cont_eff, trig_src, trig_eff, exp_lat_reg;
  logic [15:0] line_cnt_reg, frame_line_reg;
  logic [31:0] exp_cnt_reg, trig_cyc;
  logic [15:0] ext_cnt_reg;
  logic        line_tick, frame_end, cont_win, exp_win, exp_win_q_reg, enter_read;
  logic        fval_raw, fval_q_reg;

  assign frame_total = active_lines_in + 16'(is_cont ? VBLANK_CONT : VBLANK_TRIG);
  assign cont_src    = (preset_shut_reg == PRESET_MANUAL) ? exp_cont_reg
                       : 16'(PRESET_CONT_LINES);
  assign cont_eff    = (cont_src > frame_total) ? frame_total : cont_src;
  assign trig_src    = (preset_shut_reg == PRESET_MANUAL) ? exp_trig_reg
                       : 16'(PRESET_TRIG_US);
  assign trig_eff    = (trig_src < 16'(MIN_TRIG_US)) ? 16'(MIN_TRIG_US) : trig_src;
  assign trig_cyc    = 32'(trig_eff) * 32'(CLK_MHZ);
  assign line_tick   = (line_cnt_reg == 16'(LINE_CYC - 1));
  assign frame_end   = line_tick && (frame_line_reg >= frame_total - 16'h0001);
  assign enter_read  = (state_reg == ST_EXTEND) && (ext_cnt_reg == 16'h0001);

  // line count is the unit of continuous exposure
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      line_cnt_reg   <= 16'h0000;
      frame_line_reg <= 16'h0000;
      exp_lat_reg    <= 16'h0000;
    end
    else if (ce_in)
    begin
      if (sync_rst_wr || enter_read)
      begin
        line_cnt_reg   <= 16'h0000;
        frame_line_reg <= 16'h0000;
      end
      else
      begin
        line_cnt_reg <= line_tick ? 16'h0000 : line_cnt_reg + 16'h0001;
        if (line_tick)
          frame_line_reg <= frame_end ? 16'h0000 : frame_line_reg + 16'h0001;
      end
      if (line_tick)
        exp_lat_reg <= cont_eff;
    end
  end

  // exposure ends at frame end so it overlaps the previous readout
  assign cont_win = (exp_lat_reg != 16'h0000)
                    && ({1'b0, frame_line_reg} + {1'b0, exp_lat_reg} >= {1'b0, frame_total});
  assign exp_win  = is_cont ? cont_win : (state_reg == ST_EXPOSE);
  assign fval_raw = (frame_line_reg < active_lines_in)
                    && (is_cont || state_reg == ST_READOUT);

  //////////////////////////////////////////////////////////////////////////
  // trigger shutter sequence

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg   <= ST_IDLE;
      exp_cnt_reg <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      case (state_reg)
        ST_IDLE:
          if (!is_cont && trig_rise && !halted_reg)
          begin
            state_reg   <= ST_EXPOSE;
            exp_cnt_reg <= trig_cyc;
          end
        ST_EXPOSE:
        begin
          exp_cnt_reg <= exp_cnt_reg - 32'h0000_0001;
          if (is_cont)
            state_reg <= ST_IDLE;
          else if (is_pulse ? trig_fall : (exp_cnt_reg <= 32'h0000_0001))
            state_reg <= ST_EXTEND;
        end
        ST_EXTEND:
          if (enter_read)
            state_reg <= ST_READOUT;
        ST_READOUT:
          if (is_cont || frame_end || sync_rst_wr)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // extension loads one cycle after the window falls; exp_win_q bridges that cycle
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      exp_win_q_reg <= 1'b0;
      ext_cnt_reg   <= 16'h0000;
    end
    else if (ce_in)
    begin
      exp_win_q_reg <= exp_win;
      if (exp_win_q_reg && !exp_win)
        ext_cnt_reg <= 16'(EXT_CYC - 1);
      else if (ext_cnt_reg != 16'h0000)
        ext_cnt_reg <= ext_cnt_reg - 16'h0001;
    end
  end

  // a trigger during readout halts video until a sync reset; the set wins
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      halted_reg <= 1'b0;
    else if (ce_in)
    begin
      if (!is_cont && trig_rise && fval_raw)
        halted_reg <= 1'b1;
      else if (sync_rst_wr)
        halted_reg <= 1'b0;
    end
  end

  assign exposure_out     = exp_win | exp_win_q_reg | (ext_cnt_reg != 16'h0000);
  assign frame_valid_out  = fval_raw & ~halted_reg;
  assign video_halted_out = halted_reg;

  //////////////////////////////////////////////////////////////////////////
  // gain

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      gain_reg <= 16'h0000;
    else if (ce_in)
    begin
      if (gain_sel_reg == GAIN_MANUAL)
        gain_reg <= (gain_man_reg > GAIN_MAX_X10) ? GAIN_MAX_X10 : gain_man_reg;
      else if (gain_sel_reg <= GAIN_TOP_CODE)
        gain_reg <= 16'(gain_sel_reg * GAIN_STEP_X10);
      else
        gain_reg <= 16'h0000;
    end
  end

  assign gain_x10_out = gain_reg;

  //////////////////////////////////////////////////////////////////////////
  // one-shot white balance

  logic [31:0]      sum_g_reg;
  logic [3:0]       div_idx_reg;
  logic [1:0][15:0] os_gain_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      os_reg      <= OS_IDLE;
      fval_q_reg  <= 1'b0;
      sum_g_reg   <= 32'h0000_0000;
      div_idx_reg <= 4'h0;
    end
    else if (ce_in)
    begin
      fval_q_reg <= frame_valid_out;
      case (os_reg)
        OS_IDLE:
          if (wb_start_wr && wb_sel_reg == WB_ONESHOT && !halted_reg)
            os_reg <= OS_WAIT;
        OS_WAIT:
        begin
          sum_g_reg <= 32'h0000_0000;
          if (frame_valid_out && !fval_q_reg)
            os_reg <= OS_SUM;
        end
        OS_SUM:
        begin
          // only in-frame pixels count, so the sum is final when the divide loads
          if (pix_valid_in && frame_valid_out)
            sum_g_reg <= sum_g_reg + 32'(pix_green_in);
          if (!frame_valid_out)
          begin
            os_reg      <= OS_DIV;
            div_idx_reg <= 4'(DIV_BITS - 1);
          end
        end
        OS_DIV:
        begin
          div_idx_reg <= div_idx_reg - 4'h1;
          if (div_idx_reg == 4'h0)
            os_reg <= OS_IDLE;
        end
        default:
          os_reg <= OS_IDLE;
      endcase
      if (wb_sel_reg != WB_ONESHOT)
        os_reg <= OS_IDLE;
    end
  end

  // restoring divide, one quotient bit a cycle; an empty colour sum clamps to the top
  for (genvar c = 0; c < 2; c++)
  begin : g_col
    logic [31:0] sum_reg;
    logic [47:0] num_reg, den_sh;
    logic [9:0]  q_reg, q_next;
    logic [11:0] px;
    logic        ge;

    assign px     = (c == 0) ? pix_red_in : pix_blue_in;
    assign den_sh = {16'h0000, sum_reg} << div_idx_reg;
    assign ge     = (num_reg >= den_sh);
    assign q_next = q_reg | (ge ? (10'h001 << div_idx_reg) : 10'h000);

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        sum_reg        <= 32'h0000_0000;
        num_reg        <= 48'h0000_0000_0000;
        q_reg          <= 10'h000;
        os_gain_reg[c] <= WB_UNITY_PCT;
      end
      else if (ce_in)
      begin
        case (os_reg)
          OS_WAIT:
            sum_reg <= 32'h0000_0000;
          OS_SUM:
          begin
            if (pix_valid_in && frame_valid_out)
              sum_reg <= sum_reg + 32'(px);
            num_reg <= 48'(sum_g_reg) * 48'(WB_UNITY_PCT);
            q_reg   <= 10'h000;
          end
          OS_DIV:
          begin
            if (ge)
              num_reg <= num_reg - den_sh;
            q_reg <= q_next;
            if (div_idx_reg == 4'h0)
              os_gain_reg[c] <= (16'(q_next) > WB_MAX_PCT) ? WB_MAX_PCT : 16'(q_next);
          end
          default:
            ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      wb_reg <= {WB_UNITY_PCT, WB_UNITY_PCT};
    else if (ce_in)
    begin
      case (wb_sel_reg)
        WB_MANUAL:
        begin
          wb_reg.red_pct  <= (wb_red_reg > WB_MAX_PCT) ? WB_MAX_PCT : wb_red_reg;
          wb_reg.blue_pct <= (wb_blue_reg > WB_MAX_PCT) ? WB_MAX_PCT : wb_blue_reg;
        end
        WB_ONESHOT:
          wb_reg <= {os_gain_reg[0], os_gain_reg[1]};
        default:
          wb_reg <= {WB_UNITY_PCT, WB_UNITY_PCT};
      endcase
    end
  end

  assign wb_out      = wb_reg;
  assign wb_busy_out = (os_reg != OS_IDLE);
  assign cfg_out     = cfg_reg;

  //////////////////////////////////////////////////////////////////////////
  // readback

  always_comb
  begin
    case (cmd_addr_in)
      ADDR_SHUT_MODE:   rd_data = shut_mode_reg;
      ADDR_TRIG_POL:    rd_data = trig_pol_reg;
      ADDR_TRIG_SRC:    rd_data = trig_src_reg;
      ADDR_GAIN_SEL:    rd_data = gain_sel_reg;
      ADDR_GAIN_MAN:    rd_data = gain_man_reg;
      ADDR_GAIN_NOW:    rd_data = gain_reg;
      ADDR_EXP_CONT:    rd_data = exp_cont_reg;
      ADDR_EXP_TRIG:    rd_data = exp_trig_reg;
      ADDR_PRESET_SHUT: rd_data = preset_shut_reg;
      ADDR_EXP_NOW:     rd_data = is_cont ? cont_eff : trig_eff;
      ADDR_WB_SEL:      rd_data = wb_sel_reg;
      ADDR_WB_RED:      rd_data = wb_red_reg;
      ADDR_WB_BLUE:     rd_data = wb_blue_reg;
      ADDR_BIT_DEPTH:   rd_data = cfg_reg.bit_depth;
      ADDR_OP_MODE:     rd_data = cfg_reg.op_mode;
      ADDR_LINK_CLK:    rd_data = cfg_reg.link_clk;
      ADDR_H_MIRROR:    rd_data = cfg_reg.h_mirror;
      ADDR_V_MIRROR:    rd_data = cfg_reg.v_mirror;
      default:          rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 16'h0000;
    end
    else if (ce_in)
    begin
      rsp_valid_reg <= rd_en;
      if (rd_en)
        rsp_data_reg <= rd_data;
    end
  end

  assign rsp_valid_out = rsp_valid_reg;
  assign rsp_data_out  = rsp_data_reg;

  //////////////////////////////////////////////////////////////////////////
  // checks

  chk_gain_manual: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (gain_sel_reg == GAIN_MANUAL && gain_man_reg <= GAIN_MAX_X10) |=> gain_reg == $past(gain_man_reg))
    else $error("manual gain not applied");
  chk_gain_preset: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (gain_sel_reg == 16'h0007) |=> gain_reg == GAIN_MAX_X10)
    else $error("top preset gain is not 42 dB");
  chk_clip_limit: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    is_cont |-> (cont_eff <= frame_total && (cont_src <= frame_total || cont_eff == frame_total)))
    else $error("continuous exposure not clipped to frame");
  chk_trig_start: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (state_reg == ST_IDLE && !is_cont && trig_rise && !halted_reg) |=> exposure_out)
    else $error("exposure late after trigger edge");
  chk_ext_length: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (exp_win_q_reg && !exp_win) |=> (ext_cnt_reg == 16'(EXT_CYC - 1)) ##1 exposure_out)
    else $error("shutter extension wrong");
  chk_fixed_min: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (state_reg == ST_IDLE && $past(state_reg) == ST_IDLE ##1 state_reg == ST_EXPOSE && !is_pulse)
    |-> exp_cnt_reg >= 32'(MIN_TRIG_US * CLK_MHZ))
    else $error("fixed exposure below minimum");
  // exposure tail after the window falls; too long for a delay range, so counted
  logic [15:0] tail_cnt_reg;

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tail_cnt_reg <= 16'h0000;
    else if (ce_in)
      tail_cnt_reg <= (exposure_out && !exp_win) ? tail_cnt_reg + 16'h0001 : 16'h0000;
  end

  chk_pulse_end: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (state_reg == ST_EXPOSE && is_pulse && trig_fall) |=> !exp_win)
    else $error("pulse exposure did not end in time");
  chk_tail_bound: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    tail_cnt_reg <= 16'(EXT_CYC))
    else $error("exposure tail longer than extension");
  chk_halt_clash: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (!is_cont && trig_rise && fval_raw) |=> (halted_reg && !frame_valid_out))
    else $error("readout clash did not halt video");
  chk_wb_off: assert property (@(posedge core_clk_in) disable iff (!arst_n_in || !ce_in)
    (wb_sel_reg == WB_OFF) [*2] |-> (wb_reg.red_pct == WB_UNITY_PCT && wb_reg.blue_pct == WB_UNITY_PCT))
    else $error("white balance off is not unity");
endmodule
`default_nettype wire

/* verification/cewb_trig_src.sv */
// Purpose: external trigger source model
// Assumes: active-high pulses, widths given in core clock cycles
// Notes: line idles low between pulses
`timescale 1ns/1ps
`default_nettype none
module cewb_trig_src (
  input  wire logic core_clk_in,
  output logic      trig_out
);
  initial trig_out = 1'b0;
  ////////////////////////////////////////////////////////////
  // callers keep widths at or above 1500 cycles (6 us)
  task automatic fire(input int cyc);
    fork
      begin
        @(posedge core_clk_in);
        trig_out <= 1'b1;
        repeat (cyc) @(posedge core_clk_in);
        trig_out <= 1'b0;
      end
    join_none
  endtask
endmodule
`default_nettype wire

/* verification/cewb_ctrl_test.sv */
// Purpose: self-checking bench for exposure, gain and balance control
// Assumes: short lines and a four-line frame to keep the run brief
// Notes: checks gain codes, balance gains, trigger exposure and halt
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module cewb_ctrl_test;
  import cewb_pkg::*;
  logic core_clk_in = 0, arst_n_in = 0, ce_in = 1, cmd_valid_in = 0, cmd_write_in = 0;
  logic [11:0] cmd_addr_in = '0, pix_red_in = '0, pix_green_in = '0, pix_blue_in = '0;
  logic [15:0] cmd_data_in = '0, rsp_data_out, gain_x10_out, d;
  logic [15:0] active_lines_in = 16'h0004;
  logic rsp_valid_out, trig_pin_in, trig_link_in = 0, pix_valid_in = 0, exposure_out;
  logic frame_valid_out, video_halted_out, wb_busy_out;
  cewb_wb_t wb_out;
  cewb_cfg_t cfg_out;
  int n_mismatch = 0, n_compared = 0, n;
  always #2 core_clk_in = ~core_clk_in;
  cewb_ctrl #(.LINE_CYC(8)) uut (.*);
  cewb_trig_src trig (.core_clk_in(core_clk_in), .trig_out(trig_pin_in));
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge core_clk_in);
    {cmd_valid_in, cmd_write_in, cmd_addr_in, cmd_data_in} <= {2'b11, a, v};
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk_in);
    {cmd_valid_in, cmd_write_in, cmd_addr_in} <= {2'b10, a};
    @(posedge core_clk_in);
    cmd_valid_in <= 1'b0;
    #1 d = rsp_data_out;
    `CK("read valid", 1'b1, rsp_valid_out)
  endtask
  // bounded wait for exposure start, then count its length
  task automatic expo(input int w);
    n = 0;
    trig.fire(w);
    repeat (32) if (exposure_out !== 1'b1) @(posedge core_clk_in);
    while (exposure_out === 1'b1 && n < 20000)
    begin
      @(posedge core_clk_in);
      n++;
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge core_clk_in);
    n_mismatch++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd(ADDR_SHUT_MODE);
    `CK("shutter mode", SHUT_CONT, d)
    wr(ADDR_GAIN_SEL, GAIN_MANUAL);
    wr(ADDR_GAIN_MAN, 16'h0069);
    `CK("manual gain", 16'h0069, gain_x10_out)
    wr(ADDR_GAIN_MAN, 16'h01f4);
    `CK("gain clamp", GAIN_MAX_X10, gain_x10_out)
    for (int c = 0; c < 8; c++)
    begin
      wr(ADDR_GAIN_SEL, 16'(c));
      `CK("preset gain", 16'(c * 60), gain_x10_out)
    end
    wr(ADDR_WB_SEL, WB_MANUAL);
    wr(ADDR_WB_RED, WB_MAX_PCT);
    wr(ADDR_WB_BLUE, 16'h0032);
    `CK("wb gains", {WB_MAX_PCT, 16'h0032}, wb_out)
    wr(ADDR_SHUT_MODE, SHUT_FIXED);
    wr(ADDR_EXP_TRIG, 16'h0002);
    expo(1600);
    `CK("fixed length", 1'b1, n inside {[4999:5001]})
    trig.fire(1600);
    repeat (10) @(posedge core_clk_in);
    `CK("halt", 2'b10, {video_halted_out, frame_valid_out})
    repeat (1700) @(posedge core_clk_in);
    wr(ADDR_SYNC_RESET, RST_ZERO);
    `CK("halt clear", 1'b0, video_halted_out)
    wr(ADDR_SHUT_MODE, SHUT_PULSE);
    repeat (1000) @(posedge core_clk_in);
    expo(3000);
    `CK("pulse length", 1'b1, n inside {[6497:6504]})
    wr(ADDR_SHUT_MODE, SHUT_CONT);
    wr(ADDR_V_MIRROR, 16'h0001);
    `CK("mirror setting", 16'h0001, cfg_out.v_mirror)
    wr(ADDR_EXP_CONT, 16'h0100);
    rd(ADDR_EXP_NOW);
    `CK("clipped exposure", 16'(4 + VBLANK_CONT), d)
    @(posedge core_clk_in);
    active_lines_in <= 16'h0200;
    wr(ADDR_PRESET_SHUT, 16'h0000);
    rd(ADDR_EXP_NOW);
    `CK("preset exposure", 16'h01f4, d)
    wr(ADDR_PRESET_SHUT, PRESET_MANUAL);
    rd(ADDR_EXP_NOW);
    `CK("restored exposure", 16'h0100, d)
    wr(ADDR_WB_SEL, WB_ONESHOT);
    {active_lines_in, pix_valid_in, pix_red_in, pix_green_in, pix_blue_in}
      <= {16'h0004, 1'b1, 12'h100, 12'h200, 12'h080};
    wr(ADDR_WB_START, 16'h0001);
    `CK("one-shot busy", 1'b1, wb_busy_out)
    repeat (600) @(posedge core_clk_in);
    `CK("one-shot gains", {16'h00c8, 16'h0190}, wb_out)
    `CK("one-shot done", 1'b0, wb_busy_out)
    wrap_up();
  end
endmodule
`default_nettype wire
